// file: aqw_top.sv
// alarm reaction and question-answer watchdog control, top module
`timescale 1ns/1ps
`default_nettype none
module aqw_top #(
  parameter int FILT1_CYC = aqw_pkg::FILT1_CYC,
  parameter int FILT2_CYC = aqw_pkg::FILT2_CYC,
  parameter int FILT3_CYC = aqw_pkg::FILT3_CYC,
  parameter int TMO0_CYC  = aqw_pkg::TMO0_CYC,
  parameter int TMO1_CYC  = aqw_pkg::TMO1_CYC,
  parameter int TMO2_CYC  = aqw_pkg::TMO2_CYC,
  parameter int TMO3_CYC  = aqw_pkg::TMO3_CYC
) (
  // clock, reset, enable
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        CE_I,
  // decoded register access from the serial frame logic
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [15:0] REG_WDATA_I,
  output var  logic [15:0] REG_RDATA_O,
  // alarm pin
  input  wire logic        ALARM_I,
  // reactions
  output var  logic        FAULT_N_O,
  output var  logic        DRV_ALL_OFF_O,
  output var  logic        DRV_MOTOR_OFF_O,
  output var  logic        PUMP_OFF_O
);
  //=====================================================================
  // declarations
  logic                      alarm_sel_reg;
  logic [1:0]                filt_reg;
  logic [2:0]                react_reg;
  logic [1:0]                period_reg;
  logic                      enable_reg;
  logic [2:0]                act_react_reg;
  logic [1:0]                act_period_reg;
  logic                      act_enable_reg;
  aqw_pkg::aqw_state_t       state_reg;
  aqw_pkg::aqw_state_t       state_next;
  logic [aqw_pkg::CNT_W-1:0] timer_reg;
  logic [3:0]                err_reg;
  logic [3:0]                seq_reg;
  logic [3:0]                prev_reg;
  logic                      trip_reg;
  logic                      sync1_reg;
  logic                      sync2_reg;
  logic                      alarm_filt;
  logic [aqw_pkg::CNT_W-1:0] filt_limit;
  logic [aqw_pkg::CNT_W-1:0] tmo_limit;

  //=====================================================================
  // functions
  function automatic logic [aqw_pkg::CNT_W-1:0] pick(input logic [1:0] sel, input int c0, input int c1,
                                                     input int c2, input int c3);
    int c;
    case (sel)
      2'h0:    c = c0;
      2'h1:    c = c1;
      2'h2:    c = c2;
      default: c = c3;
    endcase
    return c[aqw_pkg::CNT_W-1:0];
  endfunction

  // expected answer derived from the sequence number
  function automatic logic [3:0] expect_of(input logic [3:0] seq);
    return {seq[0], seq[3:1]} ^ aqw_pkg::ANSWER_MIX;
  endfunction

  //=====================================================================
  // register decode
  wire wr_alarm  = REG_WR_I && REG_ADDR_I == aqw_pkg::ALARM_REACTION_CONTROL_WADDR;
  wire wr_ctrl   = REG_WR_I && REG_ADDR_I == aqw_pkg::WATCHDOG_CONTROL_WADDR;
  wire wr_answer = REG_WR_I && REG_ADDR_I == aqw_pkg::WATCHDOG_ANSWER_WADDR;
  wire [2:0] react_in = REG_WDATA_I[aqw_pkg::REACT_LSB +: 3];
  wire react_ok = react_in >= aqw_pkg::REACT_FAULT_ONLY && react_in <= aqw_pkg::REACT_ALL_PUMP;
  wire [3:0] cmd  = REG_WDATA_I[aqw_pkg::CMD_LSB +: 4];
  wire [3:0] resp = REG_WDATA_I[aqw_pkg::RESP_LSB +: 4];
  wire running    = state_reg == aqw_pkg::AQW_RUN;
  wire cmd_start  = wr_answer && cmd == aqw_pkg::CMD_START;
  wire cmd_stop   = wr_answer && cmd == aqw_pkg::CMD_STOP;
  wire cmd_answer = wr_answer && cmd == aqw_pkg::CMD_ANSWER;
  wire cmd_bad    = wr_answer && running && !cmd_start && !cmd_stop && !cmd_answer;
  wire ans_good   = cmd_answer && running && resp == expect_of(seq_reg);
  wire ans_wrong  = cmd_answer && running && !ans_good;
  wire timed_out  = running && act_enable_reg && timer_reg >= tmo_limit - 17'h00001;
  wire err_event  = cmd_bad || ans_wrong || timed_out;
  wire err_sat    = err_reg == 4'hf;
  wire trip_now   = running && err_reg >= aqw_pkg::ACC_LIMIT;

  //=====================================================================
  // selected lengths
  assign filt_limit = pick(filt_reg, aqw_pkg::FILT0_CYC, FILT1_CYC, FILT2_CYC, FILT3_CYC);
  assign tmo_limit  = pick(act_period_reg, TMO0_CYC, TMO1_CYC, TMO2_CYC, TMO3_CYC);

  //=====================================================================
  // alarm pin synchroniser, then filter
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else if (CE_I) begin
      sync1_reg <= ALARM_I;
      sync2_reg <= sync1_reg;
    end
  end

  aqw_filter u_filter (
    .clk_i   (CLK_I),
    .rst_i   (RESET_I),
    .ce_i    (CE_I),
    .raw_i   (sync2_reg),
    .limit_i (filt_limit),
    .filt_o  (alarm_filt)
  );

  //=====================================================================
  // control registers; unlisted reaction codes are dropped
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      alarm_sel_reg <= aqw_pkg::ALARM_SEL_RST;
      filt_reg      <= aqw_pkg::FILT_RST;
      react_reg     <= aqw_pkg::REACT_RST;
      period_reg    <= aqw_pkg::PERIOD_RST;
      enable_reg    <= aqw_pkg::ENABLE_RST;
    end else if (CE_I) begin
      if (wr_alarm) begin
        alarm_sel_reg <= REG_WDATA_I[aqw_pkg::ALARM_SEL_BIT];
        filt_reg      <= REG_WDATA_I[aqw_pkg::FILT_LSB +: 2];
      end
      if (wr_ctrl) begin
        if (react_ok) begin
          react_reg <= react_in;
        end
        period_reg <= REG_WDATA_I[aqw_pkg::PERIOD_LSB +: 2];
        enable_reg <= REG_WDATA_I[aqw_pkg::ENABLE_BIT];
      end
    end
  end

  //=====================================================================
  // settings used by the watchdog are latched only at start
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      act_react_reg  <= aqw_pkg::REACT_RST;
      act_period_reg <= aqw_pkg::PERIOD_RST;
      act_enable_reg <= aqw_pkg::ENABLE_RST;
    end else if (CE_I && cmd_start) begin
      act_react_reg  <= react_reg;
      act_period_reg <= period_reg;
      act_enable_reg <= enable_reg;
    end
  end

  //=====================================================================
  // sequence state
  always_comb begin
    case (state_reg)
      aqw_pkg::AQW_IDLE: state_next = cmd_start ? aqw_pkg::AQW_RUN : aqw_pkg::AQW_IDLE;
      aqw_pkg::AQW_RUN:  state_next = cmd_stop ? aqw_pkg::AQW_IDLE : aqw_pkg::AQW_RUN;
      default:           state_next = aqw_pkg::AQW_IDLE;
    endcase
  end

  // a good answer advances the sequence and restarts the timeout
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_reg <= aqw_pkg::AQW_IDLE;
      timer_reg <= '0;
      err_reg   <= '0;
      seq_reg   <= '0;
      prev_reg  <= aqw_pkg::PREV_RST;
      trip_reg  <= 1'b0;
    end else if (CE_I) begin
      state_reg <= state_next;
      if (cmd_start || ans_good || timed_out || !running) begin
        timer_reg <= '0;
      end else begin
        timer_reg <= timer_reg + 17'h00001;
      end
      if (err_event && !err_sat) begin
        err_reg <= err_reg + 4'h1;
      end
      if (ans_good) begin
        prev_reg <= expect_of(seq_reg);
        seq_reg  <= seq_reg + 4'h1;
      end
      if (trip_now) begin
        trip_reg <= 1'b1;
      end
    end
  end

  //=====================================================================
  // reaction outputs: alarm follows the filtered level, watchdog trip holds
  wire wd_all   = trip_reg && (act_react_reg == aqw_pkg::REACT_ALL_OFF || act_react_reg == aqw_pkg::REACT_ALL_PUMP);
  wire wd_motor = trip_reg && act_react_reg == aqw_pkg::REACT_MOTOR_OFF;
  wire wd_pump  = trip_reg && act_react_reg == aqw_pkg::REACT_ALL_PUMP;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      FAULT_N_O       <= 1'b1;
      DRV_ALL_OFF_O   <= 1'b0;
      DRV_MOTOR_OFF_O <= 1'b0;
      PUMP_OFF_O      <= 1'b0;
    end else if (CE_I) begin
      FAULT_N_O       <= !(alarm_filt || trip_reg);
      DRV_ALL_OFF_O   <= (alarm_filt && !alarm_sel_reg) || wd_all;
      DRV_MOTOR_OFF_O <= (alarm_filt && alarm_sel_reg) || wd_motor;
      PUMP_OFF_O      <= wd_pump;
    end
  end

  //=====================================================================
  // read-back; unmapped addresses read zero
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      REG_RDATA_O <= '0;
    end else if (CE_I && REG_RD_I) begin
      case (REG_ADDR_I)
        aqw_pkg::ALARM_REACTION_CONTROL_RADDR: REG_RDATA_O <= {3'h0, alarm_sel_reg, 10'h000, filt_reg};
        aqw_pkg::WATCHDOG_CONTROL_RADDR: REG_RDATA_O <= {1'b0, react_reg, 2'h0, period_reg, 7'h00, enable_reg};
        aqw_pkg::WATCHDOG_STATUS_RADDR:  REG_RDATA_O <= {4'h0, err_reg, seq_reg, prev_reg};
        default: REG_RDATA_O <= '0;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: aqw_pkg.sv
// package of constants for the alarm and question-answer watchdog control block
//=====================================================================
package aqw_pkg;
  //=====================================================================
  // register addresses (write side, read side)
  localparam logic [7:0] ALARM_REACTION_CONTROL_WADDR = 8'h48;
  localparam logic [7:0] ALARM_REACTION_CONTROL_RADDR = 8'hc8;
  localparam logic [7:0] WATCHDOG_CONTROL_WADDR       = 8'h4c;
  localparam logic [7:0] WATCHDOG_CONTROL_RADDR       = 8'hcc;
  localparam logic [7:0] WATCHDOG_ANSWER_WADDR        = 8'h50;
  localparam logic [7:0] WATCHDOG_STATUS_RADDR        = 8'hd0;
  //=====================================================================
  // field positions
  localparam int ALARM_SEL_BIT   = 12;
  localparam int FILT_LSB        = 0;
  localparam int REACT_LSB       = 12;
  localparam int PERIOD_LSB      = 8;
  localparam int ENABLE_BIT      = 0;
  localparam int CMD_LSB         = 4;
  localparam int RESP_LSB        = 0;
  localparam int ERRCNT_LSB      = 8;
  localparam int SEQ_LSB         = 4;
  localparam int PREV_LSB        = 0;
  //=====================================================================
  // reset values
  localparam logic       ALARM_SEL_RST = 1'b0;
  localparam logic [1:0] FILT_RST      = 2'h0;
  localparam logic [2:0] REACT_RST     = 3'h1;
  localparam logic [1:0] PERIOD_RST    = 2'h0;
  localparam logic       ENABLE_RST    = 1'b0;
  localparam logic [3:0] PREV_RST      = 4'hf;
  //=====================================================================
  // commands and reactions
  localparam logic [3:0] CMD_STOP   = 4'h5;
  localparam logic [3:0] CMD_ANSWER = 4'h7;
  localparam logic [3:0] CMD_START  = 4'ha;
  localparam logic [2:0] REACT_FAULT_ONLY = 3'h1;
  localparam logic [2:0] REACT_ALL_OFF    = 3'h2;
  localparam logic [2:0] REACT_MOTOR_OFF  = 3'h3;
  localparam logic [2:0] REACT_ALL_PUMP   = 3'h4;
  localparam logic [3:0] ACC_LIMIT        = 4'h4;
  localparam logic [3:0] ANSWER_MIX       = 4'h5;
  //=====================================================================
  // timing: clock 10 MHz, reference 4 MHz (250 ns)
  localparam int CNT_W      = 17;
  localparam int CLK_KHZ    = 10000;
  localparam int REF_NS     = 250;
  localparam int FILT0_NS   = 16 * 4 * REF_NS + REF_NS;
  localparam int FILT1_NS   = 1000 * 4 * REF_NS + REF_NS;
  localparam int FILT2_NS   = 2000 * 4 * REF_NS + REF_NS;
  localparam int FILT3_NS   = 4000 * 4 * REF_NS + REF_NS;
  localparam int TMO0_MS    = 1;
  localparam int TMO1_MS    = 2;
  localparam int TMO2_MS    = 4;
  localparam int TMO3_MS    = 8;
  // least filter times round up, timeouts are exact cycle counts
  localparam int FILT0_CYC  = (FILT0_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int FILT1_CYC  = (FILT1_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int FILT2_CYC  = (FILT2_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int FILT3_CYC  = (FILT3_NS * (CLK_KHZ / 1000) + 999) / 1000;
  localparam int TMO0_CYC   = TMO0_MS * CLK_KHZ;
  localparam int TMO1_CYC   = TMO1_MS * CLK_KHZ;
  localparam int TMO2_CYC   = TMO2_MS * CLK_KHZ;
  localparam int TMO3_CYC   = TMO3_MS * CLK_KHZ;
  //=====================================================================
  // watchdog states
  typedef enum logic [1:0] {
    AQW_IDLE = 2'b01,
    AQW_RUN  = 2'b10
  } aqw_state_t;
endpackage

// file: aqw_filter.sv
// digital level filter for the synchronised alarm input
`timescale 1ns/1ps
`default_nettype none
module aqw_filter (
  // clock and control
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  // level in, settle length, filtered level out
  input  wire logic                      raw_i,
  input  wire logic [aqw_pkg::CNT_W-1:0] limit_i,
  output var  logic                      filt_o
);
  logic [aqw_pkg::CNT_W-1:0] cnt_reg;
  logic                      differ;
  logic                      settled;

  //=====================================================================
  // level must differ for the full length before it is passed on
  assign differ  = raw_i != filt_o;
  assign settled = cnt_reg >= limit_i - 17'h00001;

  // a single glitch restarts the count, so short pulses never pass
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      filt_o  <= 1'b0;
    end else if (ce_i) begin
      if (!differ) begin
        cnt_reg <= '0;
      end else if (settled) begin
        cnt_reg <= '0;
        filt_o  <= raw_i;
      end else begin
        cnt_reg <= cnt_reg + 17'h00001;
      end
    end
  end
endmodule
`default_nettype wire

// file: aqw_props.sv
// checker for the alarm and watchdog control ports
`timescale 1ns/1ps
`default_nettype none
module aqw_checker (
  // clock, reset, enable
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  input wire logic        CE_I,
  // register access
  input wire logic        REG_WR_I,
  input wire logic        REG_RD_I,
  input wire logic [7:0]  REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic [15:0] REG_RDATA_O,
  // reactions
  input wire logic        FAULT_N_O,
  input wire logic        DRV_ALL_OFF_O,
  input wire logic        DRV_MOTOR_OFF_O,
  input wire logic        PUMP_OFF_O
);
  //=====================================================================
  // shadow of the stored fields; refused codes never reach it
  logic [2:0] react_reg;
  logic [2:0] alarm_reg;
  wire        rd_take = CE_I && REG_RD_I && !REG_WR_I;
  wire        wr_take = CE_I && REG_WR_I;
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      react_reg <= 3'h1;
      alarm_reg <= 3'h0;
    end else if (wr_take && REG_ADDR_I == 8'h4c && REG_WDATA_I[14:12] inside {[3'h1:3'h4]}) begin
      react_reg <= REG_WDATA_I[14:12];
    end else if (wr_take && REG_ADDR_I == 8'h48) begin
      alarm_reg <= {REG_WDATA_I[12], REG_WDATA_I[1:0]};
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  //=====================================================================
  // assertions
  reset_outs_a: assert property (disable iff (1'b0) RESET_I && CE_I |=> FAULT_N_O && !DRV_ALL_OFF_O
    && !DRV_MOTOR_OFF_O && !PUMP_OFF_O && REG_RDATA_O == 16'h0000) else $error("outputs not cleared by reset");
  rdata_hold_a: assert property (!(CE_I && REG_RD_I) |=> $stable(REG_RDATA_O)) else $error("read data moved");
  unmapped_zero_a: assert property (rd_take && !(REG_ADDR_I inside {8'hc8, 8'hcc, 8'hd0})
    |=> REG_RDATA_O == 16'h0000) else $error("unmapped read not zero");
  react_keep_a: assert property (rd_take && REG_ADDR_I == 8'hcc |=> REG_RDATA_O[14:12] == react_reg)
    else $error("reaction field wrong");
  alarm_echo_a: assert property (rd_take && REG_ADDR_I == 8'hc8
    |=> {REG_RDATA_O[12], REG_RDATA_O[1:0]} == alarm_reg) else $error("alarm field wrong");
  status_top_a: assert property (rd_take && REG_ADDR_I == 8'hd0 |=> REG_RDATA_O[15:12] == 4'h0)
    else $error("status top bits set");
  pump_all_a: assert property (PUMP_OFF_O |-> DRV_ALL_OFF_O && !FAULT_N_O) else $error("pump off alone");
  drv_fault_a: assert property (DRV_ALL_OFF_O || DRV_MOTOR_OFF_O |-> !FAULT_N_O) else $error("drive off, no fault");
  trip_hold_a: assert property (PUMP_OFF_O |=> PUMP_OFF_O [*3]) else $error("pump trip released");
  // main scenarios
  alarm_c: cover property ($fell(FAULT_N_O) && !PUMP_OFF_O);
  pump_c: cover property ($rose(PUMP_OFF_O));
  status_c: cover property (rd_take && REG_ADDR_I == 8'hd0);
endmodule
`default_nettype wire

// file: aqw_host.sv
// host model driving the decoded register strobes
`timescale 1ns/1ps
`default_nettype none
module aqw_host (
  // clock and read data
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  // register strobes
  output var  logic        wr_o,
  output var  logic        rd_o,
  output var  logic [7:0]  addr_o,
  output var  logic [15:0] wdata_o
);
  //=====================================================================
  // bus tasks, driven off the falling edge
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 16'h0000;
  end
  // command and response travel in one word; data inverted once released
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  // read data is registered, so take it one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// file: aqw_top_bench.sv
// self-checking bench for the alarm and watchdog control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, a); end end
module aqw_top_bench;
  //=====================================================================
  // clock, stimulus and bookkeeping
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, alarm = 1'b0, wr, rd, fault_n, all_off, motor_off, pump_off;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, d;
  logic [3:0] s, e;
  logic [3:0] bad [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
  logic [31:0] rnd = 32'h28f5;
  int num_errors = 0, checks = 0, cyc = 0;
  always #50 clk = ~clk;
  aqw_host aqw_host_inst (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
  aqw_top #(.FILT1_CYC(20), .TMO0_CYC(50), .TMO1_CYC(60), .TMO2_CYC(70),
    .TMO3_CYC(80)) aqw_top_inst (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .ALARM_I(alarm), .FAULT_N_O(fault_n),
    .DRV_ALL_OFF_O(all_off), .DRV_MOTOR_OFF_O(motor_off), .PUMP_OFF_O(pump_off));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // answer expected for a given sequence number
  function automatic logic [3:0] expv(input logic [3:0] q);
    return {q[0], q[3:1]} ^ 4'h5;
  endfunction
  // timeout length per period code, matching the shortened overrides above
  function automatic int tmo_of(input logic [1:0] p);
    return 50 + 10 * p;
  endfunction
  task automatic do_reset();
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // hang guard, well above the thousand or so cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  //=====================================================================
  // scenarios
  initial begin
    do_reset();
    aqw_host_inst.rd(8'hc8, d); `CHK("alarm reg", 16'h0000, d)
    aqw_host_inst.rd(8'hcc, d); `CHK("control reg", 16'h1000, d)
    aqw_host_inst.rd(8'hd0, d); `CHK("status reg", 16'h000f, d)
    aqw_host_inst.rd(8'h60, d); `CHK("unmapped", 16'h0000, d)
    rnd = lfsr(rnd);
    aqw_host_inst.wr(8'h4c, {4'h0, 2'b00, rnd[1:0], 7'h00, rnd[2]});
    aqw_host_inst.rd(8'hcc, d); `CHK("refused code", {4'h1, 2'b00, rnd[1:0], 7'h00, rnd[2]}, d)
    // alarm: filter code 01 settles in 20 cycles plus synchroniser
    aqw_host_inst.wr(8'h48, 16'h1001);
    alarm = 1'b1;
    repeat (10) @(negedge clk);
    `CHK("filter holds", 1'b1, fault_n)
    repeat (20) @(negedge clk);
    `CHK("alarm fault", 1'b0, fault_n)
    `CHK("motor off", 1'b1, motor_off)
    alarm = 1'b0;
    aqw_host_inst.wr(8'h48, 16'h0001);
    repeat (30) @(negedge clk);
    `CHK("alarm release", 1'b1, fault_n)
    alarm = 1'b1;
    repeat (30) @(negedge clk);
    `CHK("all off", 1'b1, all_off)
    alarm = 1'b0;
    repeat (30) @(negedge clk);
    // filter code 00: 163 cycles plus synchroniser and output stage
    aqw_host_inst.wr(8'h48, 16'h0000);
    alarm = 1'b1;
    repeat (160) @(negedge clk);
    `CHK("short filter holds", 1'b1, fault_n)
    repeat (10) @(negedge clk);
    `CHK("short filter", 1'b0, fault_n)
    alarm = 1'b0;
    repeat (170) @(negedge clk);
    `CHK("short release", 1'b1, fault_n)
    // good answers then one wrong answer
    aqw_host_inst.wr(8'h4c, 16'h1000);
    aqw_host_inst.wr(8'h50, 16'h00a0);
    for (s = 4'h0; s < 4'h3; s++) begin
      e = expv(s);
      aqw_host_inst.wr(8'h50, {8'h00, 4'h7, e});
      aqw_host_inst.rd(8'hd0, d); `CHK("good answer", {8'h00, s + 4'h1, e}, d)
    end
    rnd = lfsr(rnd);
    aqw_host_inst.wr(8'h50, {8'h00, 4'h7, expv(s) ^ (rnd[3:0] | 4'h1)});
    aqw_host_inst.rd(8'hd0, d); `CHK("wrong answer", {8'h01, s, e}, d)
    // timeout: random period code, 50 to 80 cycles, only while running
    do_reset();
    rnd = lfsr(rnd);
    aqw_host_inst.wr(8'h4c, {6'h04, rnd[9:8], 8'h01});
    aqw_host_inst.wr(8'h50, 16'h00a0);
    repeat (tmo_of(rnd[9:8]) - 10) @(negedge clk);
    aqw_host_inst.rd(8'hd0, d); `CHK("before timeout", 16'h000f, d)
    // a frozen enable must hold the timer across several timeout periods
    ce = 1'b0;
    repeat (200) @(negedge clk);
    ce = 1'b1;
    repeat (20) @(negedge clk);
    aqw_host_inst.rd(8'hd0, d); `CHK("timeout", 16'h010f, d)
    aqw_host_inst.wr(8'h50, 16'h0050);
    aqw_host_inst.wr(8'h50, 16'h0030);
    repeat (60) @(negedge clk);
    aqw_host_inst.rd(8'hd0, d); `CHK("stopped", 16'h010f, d)
    // each reaction, captured at start despite a later rewrite
    for (int r = 1; r <= 4; r++) begin
      do_reset();
      aqw_host_inst.wr(8'h4c, {1'b0, 3'(r), 12'h000});
      aqw_host_inst.wr(8'h50, 16'h00a0);
      aqw_host_inst.wr(8'h4c, {1'b0, (r == 4) ? 3'h1 : 3'h4, 12'h000});
      for (int k = 0; k < 4; k++) begin
        rnd = lfsr(rnd);
        aqw_host_inst.wr(8'h50, {8'h00, bad[rnd % 13], rnd[7:4]});
        repeat (3) @(negedge clk);
        if (k == 2) `CHK("below limit", 1'b1, fault_n)
      end
      aqw_host_inst.rd(8'hd0, d); `CHK("error count", 4'h4, d[11:8])
      `CHK("trip fault", 1'b0, fault_n)
      `CHK("trip all off", r == 2 || r == 4, all_off)
      `CHK("trip pump", r == 4, pump_off)
      if (r == 1 || r == 3) `CHK("trip motor", r == 3, motor_off)
    end
    results();
  end
endmodule
bind aqw_top aqw_checker aqw_checker_inst (.CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O),
  .FAULT_N_O(FAULT_N_O), .DRV_ALL_OFF_O(DRV_ALL_OFF_O), .DRV_MOTOR_OFF_O(DRV_MOTOR_OFF_O), .PUMP_OFF_O(PUMP_OFF_O));
`default_nettype wire
